// File: rtl/llsw_mdio.v
// Purpose: Management serial port slave, register read and write strobes
// Assumes: MDC well below CLK_I/6; pins asynchronous to CLK_I
// Notes:   Read data is captured in the cycle of the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "llsw_regs.vh"

module llsw_mdio (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Pins
	input  wire        mdc_i,
	input  wire        mdio_i,
	input  wire [4:0]  prtad_i,
	output reg         mdio_o,
	output reg         mdio_oe_o,
	// Register side
	output reg  [4:0]  reg_addr_o,
	output reg         rd_o,
	output reg         wr_o,
	output reg  [15:0] wdata_o,
	input  wire [15:0] rdata_i
);
	localparam ST_IDLE = 2'h0;
	localparam ST_HDR  = 2'h1;
	localparam ST_RD   = 2'h2;
	localparam ST_WR   = 2'h3;

	reg  [6:0]  s1_q, s2_q, s3_q, stab_q;
	reg  [1:0]  state_q;
	reg  [4:0]  cnt_q;
	reg  [12:0] hdr_q;
	reg  [15:0] sh_q;
	reg         prev_q;
	wire [6:0]  agree = ~(s2_q ^ s3_q);
	wire [6:0]  stab_d = (s2_q & agree) | (stab_q & ~agree);
	wire        mdc_rise = stab_d[0] & ~stab_q[0];
	wire        bit_in = stab_q[1];
	wire [12:0] hdr_d = {hdr_q[11:0], bit_in};

	// Three-stage pin capture; a change counts once stages two and three agree
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_q   <= 7'h00;
			s2_q   <= 7'h00;
			s3_q   <= 7'h00;
			stab_q <= 7'h00;
		end else begin
			s1_q   <= {prtad_i, mdio_i, mdc_i};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			stab_q <= stab_d;
		end
	end

	// Frame sequencer, acting on each MDC rising edge
	always @(posedge clk_i) begin
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		if (rst_i) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 5'h00;
			hdr_q      <= 13'h0000;
			sh_q       <= 16'h0000;
			prev_q     <= 1'b0;
			mdio_o     <= 1'b0;
			mdio_oe_o  <= 1'b0;
			reg_addr_o <= 5'h00;
			wdata_o    <= 16'h0000;
		end else if (rd_o) begin
			sh_q <= rdata_i;   // Data sampled before any read side effect lands
		end else if (mdc_rise) begin
			prev_q <= bit_in;
			case (state_q)
				ST_IDLE: begin
					// Idle-high line then a zero marks the start field
					if (prev_q && !bit_in) begin
						state_q <= ST_HDR;
						cnt_q   <= 5'h00;
					end
				end
				ST_HDR: begin
					hdr_q <= hdr_d;
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q[3:0] == `LLSW_HDR_BITS - 4'h1) begin
						cnt_q      <= 5'h00;
						reg_addr_o <= hdr_d[4:0];
						// Only the upper four address bits select this device
						if (hdr_d[12] != 1'b1 || hdr_d[9:6] != stab_q[6:3])
							state_q <= ST_IDLE;
						else if (hdr_d[11:10] == `LLSW_OP_READ) begin
							state_q <= ST_RD;
							rd_o    <= 1'b1;
						end else if (hdr_d[11:10] == `LLSW_OP_WRITE)
							state_q <= ST_WR;
						else
							state_q <= ST_IDLE;
					end
				end
				ST_RD: begin
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q == 5'h00) begin
						mdio_oe_o <= 1'b1;   // Second turnaround bit driven low
						mdio_o    <= 1'b0;
					end else if (cnt_q == 5'h11) begin
						mdio_oe_o <= 1'b0;
						state_q   <= ST_IDLE;
					end else begin
						mdio_o <= sh_q[15];
						sh_q   <= {sh_q[14:0], 1'b0};
					end
				end
				ST_WR: begin
					cnt_q   <= cnt_q + 5'h01;
					wdata_o <= {wdata_o[14:0], bit_in};
					if (cnt_q == 5'h11) begin
						wr_o    <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule // llsw_mdio
`default_nettype wire

// File: rtl/llsw_regs.vh
// Purpose: Constants for the link latency stopwatch and its management port
// Assumes: Clause 22 style management frames, 16-bit registers
// Notes:   Offsets are register numbers within the management space
`ifndef LLSW_REGS_VH
`define LLSW_REGS_VH

// Register numbers
`define LLSW_REG_CTRL        5'h16
`define LLSW_REG_STAT_HI     5'h17
`define LLSW_REG_RES_LO      5'h18

// Control register fields
`define LLSW_CTRL_CLK_EN     0
`define LLSW_CTRL_BYTE_CLK   2
`define LLSW_CTRL_DIV_LSB    4
`define LLSW_CTRL_DIV_MSB    5
`define LLSW_CTRL_STOP_LOC   6
`define LLSW_CTRL_START_LOC  7
`define LLSW_CTRL_CHAN       8
`define LLSW_CTRL_RESET      16'h0000

// Upper status register fields
`define LLSW_STAT_DONE       4
`define LLSW_STAT_START_POS  5
`define LLSW_STAT_STOP_POS   6
`define LLSW_STAT_PTR_LSB    8

// Result counter
`define LLSW_CNT_W           20
`define LLSW_CNT_MAX         20'hFFFFF

// Comma-bearing control characters
`define LLSW_K28_1           8'h3C
`define LLSW_K28_5           8'hBC
`define LLSW_K28_7           8'hFC
`define LLSW_CHAR_W          18

// Management frame codes
`define LLSW_OP_READ         2'h2
`define LLSW_OP_WRITE        2'h1
`define LLSW_HDR_BITS        4'hD

`endif

// File: rtl/llsw_top.v
// Purpose: Per-channel comma-to-comma latency stopwatch with management access
// Assumes: Comma words and clock ticks arrive on CLK_I as one-cycle enables
//          Probe words are two bytes, earlier byte in the low half
// Notes:   Upper status must be read before the low result word
//          Result holds at the maximum once the counter range is exceeded
//          Only one channel is measured at a time; one counter serves both
//
// Behaviour
// - Low result read clears and rearms stopwatch
// - Done flag at upper status bit four
// - Comma locations and lane pointers are readable
// - Result split four high, sixteen low bits
// - No start comma means result stays zero
// - Counter saturates at maximum on overflow
// - Low read clears counter, done and locations
// - Undivided clock tracks line rate and mode
// - Commas are three K characters with control
// - First start comma starts, first stop stops
// - High-speed tick comes from rate-scaled clock
// - Divider one to eight, or byte clock
`timescale 1ns/1ps
`default_nettype none
`include "llsw_regs.vh"

module llsw_top (
	// Clock and reset
	input  wire        CLK_I,
	input  wire        RST_I,
	// Management pins
	input  wire        MDC_I,
	input  wire        MDIO_I,
	input  wire [4:0]  PRTAD_I,
	output wire        MDIO_O,
	output wire        MDIO_OE_O,
	// Comma probes {chB loc1, chB loc0, chA loc1, chA loc0}, 18 bits each
	input  wire [71:0] TX_CHAR_I,
	input  wire [71:0] RX_CHAR_I,
	// Measurement ticks and lane pointers per channel
	input  wire [1:0]  HS_TICK_I,
	input  wire [1:0]  BYTE_TICK_I,
	input  wire [15:0] ALIGN_PTR_I,
	// Status
	output reg         MEAS_CLK_EN_O,
	output reg         LAT_DONE_O
);
	// Stopwatch phases; only one result is held at a time
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_DONE = 2'h2;

	// Strobes and address from the management slave
	wire [4:0]  reg_addr;
	wire        rd_stb;
	wire        wr_stb;
	wire [15:0] wdata;
	reg  [15:0] rdata;
	// Control word and measurement state
	reg  [15:0] ctrl_q;
	reg  [1:0]  state_q;
	reg  [19:0] cnt_q;
	reg  [15:0] low_shadow_q;
	reg  [2:0]  div_q;
	reg         start_pos_q;
	reg         stop_pos_q;
	reg  [7:0]  ptr_q;

	// One comma-bearing control character
	// A data byte of the same value with the control flag clear is no comma
	function is_comma;
		input [8:0] c;
		begin
			is_comma = c[8] && (c[7:0] == `LLSW_K28_1 || c[7:0] == `LLSW_K28_5 ||
				c[7:0] == `LLSW_K28_7);
		end
	endfunction

	// Two-byte word: {hit, byte position}, earlier byte wins
	// Position lets software correct the count by half a word
	function [1:0] word_hit;
		input [17:0] w;
		begin
			if (is_comma(w[8:0]))
				word_hit = 2'h2;
			else if (is_comma(w[17:9]))
				word_hit = 2'h3;
			else
				word_hit = 2'h0;
		end
	endfunction

	// Management slave; read data is taken before the clear lands
	llsw_mdio u_mdio (
		.clk_i      (CLK_I),
		.rst_i      (RST_I),
		.mdc_i      (MDC_I),
		.mdio_i     (MDIO_I),
		.prtad_i    (PRTAD_I),
		.mdio_o     (MDIO_O),
		.mdio_oe_o  (MDIO_OE_O),
		.reg_addr_o (reg_addr),
		.rd_o       (rd_stb),
		.wr_o       (wr_stb),
		.wdata_o    (wdata),
		.rdata_i    (rdata)
	);

	// Probe and tick selection for the channel under test
	// Locations stay fixed for a measurement; a new channel needs a new control write
	wire       chan      = ctrl_q[`LLSW_CTRL_CHAN];
	wire [1:0] tx_idx    = {chan, ctrl_q[`LLSW_CTRL_START_LOC]};
	wire [1:0] rx_idx    = {chan, ctrl_q[`LLSW_CTRL_STOP_LOC]};
	// Each probe is one eighteen-bit word picked by channel and location
	wire [1:0] start_hit = word_hit(TX_CHAR_I[tx_idx * `LLSW_CHAR_W +: `LLSW_CHAR_W]);
	wire [1:0] stop_hit  = word_hit(RX_CHAR_I[rx_idx * `LLSW_CHAR_W +: `LLSW_CHAR_W]);
	wire [1:0] div_sel   = ctrl_q[`LLSW_CTRL_DIV_MSB:`LLSW_CTRL_DIV_LSB];
	// Mask of ones selects one tick in each group of one to eight
	wire [2:0] div_mask  = (3'h1 << div_sel) - 3'h1;
	// Rate-mode scaling happens upstream; this tick already follows the line rate
	wire       hs_tick   = HS_TICK_I[chan];
	// Byte clock bypasses the divider entirely
	wire       meas_tick = ctrl_q[`LLSW_CTRL_BYTE_CLK] ? BYTE_TICK_I[chan] :
		(hs_tick && ((div_q & div_mask) == div_mask));
	// Register side effects keyed on the decoded address
	wire       clr_rd    = rd_stb && (reg_addr == `LLSW_REG_RES_LO);
	wire       hi_rd     = rd_stb && (reg_addr == `LLSW_REG_STAT_HI);
	// Saturate rather than wrap, so an overrange never reads as a short delay
	wire [19:0] cnt_inc  = (cnt_q == `LLSW_CNT_MAX) ? cnt_q : cnt_q + 20'h00001;

	// Read data; unmapped registers return zero
	// Bit seven of the upper status reads zero
	always @* begin
		case (reg_addr)
			`LLSW_REG_CTRL:    rdata = ctrl_q;
			`LLSW_REG_STAT_HI: rdata = {ptr_q, 1'b0, stop_pos_q, start_pos_q,
				(state_q == ST_DONE), cnt_q[19:16]};
			`LLSW_REG_RES_LO:  rdata = low_shadow_q;
			default:           rdata = 16'h0000;
		endcase
	end

	// Control register; writes to read-only words are dropped
	// Whole word is stored, so spare bits read back as written
	always @(posedge CLK_I) begin
		if (RST_I)
			ctrl_q <= `LLSW_CTRL_RESET;
		else if (wr_stb && reg_addr == `LLSW_REG_CTRL)
			ctrl_q <= wdata;
	end

	// Measurement clock divider, restarted with each measurement
	// Restart keeps the first divided tick a full period after the start comma
	always @(posedge CLK_I) begin
		if (RST_I || state_q == ST_IDLE)
			div_q <= 3'h0;
		else if (hs_tick)
			div_q <= div_q + 3'h1;
	end

	// Stopwatch sequencer; a low-word read rearms from any state
	// Clear wins over a stop in the same cycle; the read need not follow a done
	// A stop before any start is ignored, so a stale receive comma is harmless
	always @(posedge CLK_I) begin
		if (RST_I || clr_rd) begin
			state_q     <= ST_IDLE;
			cnt_q       <= 20'h00000;
			start_pos_q <= 1'b0;
			stop_pos_q  <= 1'b0;
			ptr_q       <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// Without a start comma the count stays zero
					if (ctrl_q[`LLSW_CTRL_CLK_EN] && start_hit[1]) begin
						state_q     <= ST_RUN;
						start_pos_q <= start_hit[0];
					end
				end
				ST_RUN: begin
					// A tick in the stop cycle still counts
					if (stop_hit[1]) begin
						state_q    <= ST_DONE;
						stop_pos_q <= stop_hit[0];
						ptr_q      <= chan ? ALIGN_PTR_I[15:8] : ALIGN_PTR_I[7:0];
					end
					if (meas_tick)
						cnt_q <= cnt_inc;
				end
				// Frozen until the low word is read
				ST_DONE: state_q <= ST_DONE;   // Held until read
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Low word frozen at the upper read so the two halves match
	// A low read without an upper read returns the word frozen earlier
	always @(posedge CLK_I) begin
		if (RST_I)
			low_shadow_q <= 16'h0000;
		else if (hi_rd)
			low_shadow_q <= cnt_q[15:0];
	end

	// Registered status pins
	// Pins lag the internal state by one cycle
	always @(posedge CLK_I) begin
		if (RST_I) begin
			MEAS_CLK_EN_O <= 1'b0;
			LAT_DONE_O    <= 1'b0;
		end else begin
			// Enable mirrors the control bit for the clock gate outside
			MEAS_CLK_EN_O <= ctrl_q[`LLSW_CTRL_CLK_EN];
			LAT_DONE_O    <= (state_q == ST_DONE);
		end
	end
endmodule // llsw_top
`default_nettype wire

// File: sim/link_latency_stopwatch_bench.sv
// Purpose: Self-checking bench for the latency stopwatch
// Assumes: Host model frames all register traffic
// Notes:   Saturation needs 2^20 ticks and is left out for run time
`timescale 1ns/1ps
`default_nettype none
module link_latency_stopwatch_bench;
	logic        clk;
	logic        rst = 1'b1;
	logic        mdc, mdio_in, mdio_out, mdio_oe, meas_en, done;
	logic [71:0] tx = '0;
	logic [71:0] rx = '0;
	logic [1:0]  hs = '0;
	logic [1:0]  bt = '0;
	logic [15:0] ptr = '0;
	logic [15:0] rd;
	logic [4:0]  pa = 5'h0A;
	logic [7:0]  ks [3] = '{8'h3C, 8'hBC, 8'hFC};
	int          n_errors, check_count;
	llsw_top llsw_top_i (.CLK_I(clk), .RST_I(rst), .MDC_I(mdc), .MDIO_I(mdio_in), .PRTAD_I(5'h0A),
		.MDIO_O(mdio_out), .MDIO_OE_O(mdio_oe), .TX_CHAR_I(tx), .RX_CHAR_I(rx), .HS_TICK_I(hs),
		.BYTE_TICK_I(bt), .ALIGN_PTR_I(ptr), .MEAS_CLK_EN_O(meas_en), .LAT_DONE_O(done));
	llsw_host llsw_host_i (.clk_i(clk), .pa_i(pa), .mdio_o_i(mdio_out), .mdio_oe_i(mdio_oe),
		.mdc_o(mdc), .line_o(mdio_in));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic rdr(input logic [4:0] a, output logic [15:0] d);
		llsw_host_i.frame(2'h2, a, 16'h0000, d);
	endtask
	// One measurement against a counting model; go low sends no start comma
	task automatic meas(input logic [15:0] c, input bit go);
		int ch, ws, wp, cnt, h, t;
		bit run, tk, stp, sps, spp;
		logic [7:0] pl, pq;
		logic [3:0] r;
		logic [71:0] kw, ko;
		logic [15:0] hi;
		ch = c[8];
		ws = ch * 2 + c[7];
		wp = ch * 2 + c[6];
		cnt = 0;
		h = 0;
		run = 0;
		pl = $urandom;
		pq = ch ? pl : ~pl;
		llsw_host_i.frame(2'h1, 5'h16, c, rd);
		rdr(5'h16, rd);
		chk("ctrl", rd, c);
		chk("enable", meas_en, c[0]);
		rdr(5'h18, rd);
		ptr <= {pl, ~pl};
		// Commas only after setup, link taken as good
		for (t = 0; t < 60; t++) begin
			@(posedge clk);
			r = $urandom;
			kw = $urandom_range(1) ? {54'h0, 1'b1, ks[t % 3], 9'h000} : {63'h0, 1'b1, ks[t % 3]};
			tk = c[2] ? r[2 + ch] : r[ch];
			stp = (t == 3 || t == 40);
			if (t == 10) sps = kw[17];
			if (t == 40) spp = kw[17];
			if (run && tk && cnt >= 0) begin
				h++;
				if (c[2] || h == (1 << c[5:4])) begin
					h = 0;
					cnt++;
				end
			end
			if (run && stp) run = 0;
			if (go && t == 10) run = 1;
			if (t > 40) run = 0;
			ko = (kw << (18 * (ws ^ 1))) | (kw << (18 * (ws ^ 2)));
			hs <= r[1:0];
			bt <= r[3:2];
			tx <= (go && (t == 10 || t == 20)) ? kw << (18 * ws) : (t == 5 ? ko : 72'h0);
			rx <= stp ? kw << (18 * wp) : (t == 30 ? (kw << (18 * (wp ^ 1))) | (kw << (18 * (wp ^ 2))) : 72'h0);
		end
		@(posedge clk);
		tx <= 72'h0;
		rx <= 72'h0;
		hs <= 2'h0;
		bt <= 2'h0;
		t = 0;
		do begin
			rdr(5'h17, hi);
			t++;
		end while (go && !hi[4] && t < 4);
		if (go && !hi[4]) begin
			chk("poll limit", 1'b0, 1'b1);
			final_report();
		end
		chk("done pin", done, go);
		chk("status", hi, {go ? pq : 8'h00, 1'b0, go && spp, go && sps, go, cnt[19:16]});
		rdr(5'h18, rd);
		chk("result", {hi[3:0], rd}, cnt[19:0]);
		rdr(5'h17, hi);
		chk("cleared", hi, 16'h0000);
		chk("done low", done, 1'b0);
	endtask
	// Main sequence: every divider, byte clock, both channels and locations
	initial begin
		logic [15:0] c;
		void'($urandom(26));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("enable at reset", meas_en, 1'b0);
		for (int i = 0; i < 8; i++) begin
			c = {7'h0, i[0], i[1], i[0] ^ i[2], i[1:0], 1'b0, i[2], 2'b01};
			meas(c, i != 5);
		end
		// Foreign address ignored, address bit zero ignored, read-only write dropped
		pa <= 5'h14;
		@(posedge clk);
		llsw_host_i.frame(2'h1, 5'h16, 16'h0000, rd);
		pa <= 5'h0B;
		@(posedge clk);
		llsw_host_i.frame(2'h1, 5'h18, 16'hFFFF, rd);
		rdr(5'h16, rd);
		chk("foreign pa", rd, c);
		rdr(5'h03, rd);
		chk("unmapped", rd, 16'h0000);
		rdr(5'h18, rd);
		chk("ro write", rd, 16'h0000);
		final_report();
	end
endmodule // link_latency_stopwatch_bench
`default_nettype wire

// File: sim/llsw_chk_assertions.sv
// Purpose: Port-level checks of the stopwatch and its management port
// Assumes: MDC period of 16 CLK_I cycles as the host model makes it
// Notes:   Read burst length follows from that period
`timescale 1ns/1ps
`default_nettype none
module llsw_chk (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        MDC_I,
	input wire logic [71:0] RX_CHAR_I,
	input wire logic        MDIO_O,
	input wire logic        MDIO_OE_O,
	input wire logic        MEAS_CLK_EN_O,
	input wire logic        LAT_DONE_O
);
	localparam int OE_CYC = 272;
	logic [8:0] oe_cnt_q;
	logic       rx_k;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// Any comma on any stop probe byte
	always_comb begin
		rx_k = 1'b0;
		for (int i = 0; i < 8; i++)
			rx_k |= RX_CHAR_I[9*i+8] && (RX_CHAR_I[9*i +: 8] inside {8'h3C, 8'hBC, 8'hFC});
	end
	// Cycles the device has driven the line
	always_ff @(posedge CLK_I)
		oe_cnt_q <= (RST_I || !MDIO_OE_O) ? 9'h000 : oe_cnt_q + 9'h001;
	sequence s_oe_burst;
		MDIO_OE_O [*8];
	endsequence
	sequence s_stop_seen;
		$past(rx_k, 2);
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) RST_I |=> !MDIO_OE_O && !LAT_DONE_O && !MEAS_CLK_EN_O)
		else $error("outputs active after reset");
	a_turn_zero: assert property ($rose(MDIO_OE_O) |-> (!MDIO_O and s_oe_burst))
		else $error("turnaround not driven low");
	a_read_len: assert property ($fell(MDIO_OE_O) |-> oe_cnt_q == OE_CYC)
		else $error("read drive length wrong");
	a_out_mdc: assert property ($changed(MDIO_O) && MDIO_OE_O |-> MDC_I)
		else $error("read data moved while MDC low");
	a_done_stop: assert property ($rose(LAT_DONE_O) |-> s_stop_seen)
		else $error("done without stop comma");
	a_done_en: assert property (LAT_DONE_O |-> MEAS_CLK_EN_O)
		else $error("done while clock disabled");
	a_done_clear: assert property ($fell(LAT_DONE_O) |-> ##[0:40] MDIO_OE_O)
		else $error("done cleared outside a read");
	a_en_write: assert property ($changed(MEAS_CLK_EN_O) |-> !MDIO_OE_O)
		else $error("enable moved during a read");
endmodule // llsw_chk
bind llsw_top llsw_chk llsw_chk_i (.CLK_I(CLK_I), .RST_I(RST_I), .MDC_I(MDC_I), .RX_CHAR_I(RX_CHAR_I),
	.MDIO_O(MDIO_O), .MDIO_OE_O(MDIO_OE_O), .MEAS_CLK_EN_O(MEAS_CLK_EN_O), .LAT_DONE_O(LAT_DONE_O));
`default_nettype wire

// File: sim/llsw_host.sv
// Purpose: Management host model that frames register reads and writes
// Assumes: MDC period of 16 CLK_I cycles, port address from the bench
// Notes:   Line is pulled up when neither side drives it
`timescale 1ns/1ps
`default_nettype none
module llsw_host (
	// Clock and address
	input  wire logic       clk_i,
	input  wire logic [4:0] pa_i,
	// Device pins
	input  wire logic       mdio_o_i,
	input  wire logic       mdio_oe_i,
	output var  logic       mdc_o,
	output wire logic       line_o
);
	logic h_oe;
	logic h_d;
	// Pull-up wins when both sides are off
	assign line_o = mdio_oe_i ? mdio_o_i : (h_oe ? h_d : 1'b1);
	initial begin
		mdc_o = 1'b0;
		h_oe = 1'b0;
		h_d = 1'b1;
	end
	// Reads release the line from the turnaround on; caller reads 0x17 before 0x18
	task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [33:0] b;
		b = {2'b11, 2'b01, op, pa_i, ra, 2'b10, wd};
		for (int i = 33; i >= -1; i--) begin
			@(posedge clk_i);
			mdc_o <= 1'b0;
			h_oe <= (i >= 18) || (op == 2'h1 && i >= 0);
			h_d <= (i >= 0) ? b[i] : 1'b1;
			repeat (8) @(posedge clk_i);
			// Data shown after the previous rise is taken before this one
			if (i >= 0 && i < 16) rd[i] = line_o;
			mdc_o <= 1'b1;
			repeat (7) @(posedge clk_i);
		end
	endtask
endmodule // llsw_host
`default_nettype wire
